// ---- include/bldc_run_pkg.sv ----
// Constants, register map and types for the sensorless run control block
`default_nettype none
package bldc_run_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_RUN  = 8'h00;
   localparam logic [7:0] OFS_CFG5 = 8'h04;
   localparam logic [7:0] OFS_DIAGNOSTIC_OUT_PIN = 8'h08;
   // Run register fields
   localparam int RUN_ENABLE_BIT   = 0;
   localparam int DIR_BIT          = 1;
   localparam int BRAKE_BIT        = 2;
   localparam int AUTO_RESTART_BIT = 3;
   localparam int DIAGNOSTIC_OUT_PIN_SEL_BIT     = 4;
   // Config register 5 fields
   localparam int RR_LSB  = 0;
   localparam int ADV_LSB = 8;
   localparam logic [3:0] RR_RST  = 4'h4;
   localparam logic [3:0] ADV_RST = 4'h0;
   // Diagnostic register fields
   localparam int FAULT_LSB   = 0;
   localparam int STATE_LSB   = 4;
   localparam int LOCKED_BIT  = 8;
   localparam int PENDING_BIT = 9;
   // Clock and times in their own units
   localparam int CLK_MHZ          = 200;
   localparam int PWM_FILTER_NS    = 200;
   localparam int BLANK_TIME_NS    = 5000;
   localparam int BOOT_TIMEOUT_NS  = 10000;
   localparam int HOLD_TIME_US     = 50000;
   localparam int START_STEP_US    = 20000;
   localparam int END_STEP_US      = 2000;
   localparam int PWM_BRAKE_US     = 2000;
   // Derived cycle counts, least times rounded up
   localparam int PWM_FILTER_CYC   = (PWM_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int BLANK_CYC        = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int BOOT_TIMEOUT_CYC = (BOOT_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC         = HOLD_TIME_US * CLK_MHZ;
   localparam int START_STEP_CYC   = START_STEP_US * CLK_MHZ;
   localparam int END_STEP_CYC     = END_STEP_US * CLK_MHZ;
   localparam int PWM_BRAKE_CYC    = PWM_BRAKE_US * CLK_MHZ;
   // Commutation state limits
   localparam logic [2:0] STATE_FIRST = 3'h1;
   localparam logic [2:0] STATE_LAST  = 3'h6;
   // Sequencer modes
   typedef enum logic [2:0] {
      MODE_IDLE,
      MODE_HOLD,
      MODE_RAMP,
      MODE_LOCKED,
      MODE_STALL
   } mode_e;
endpackage
`default_nettype wire

// ---- hdl/sensorless_bldc_run_control.sv ----
// Sensorless BLDC run control with AHB-Lite register slave
//
// Functional notes
// - Speed output low from start until first zero crossing, then high/low per cycle.
// - Sensorless reached shows as pending flag zero and diagnostic pin high.
// - Ramp end without lock and auto restart set restarts the start sequence.
// - Ramp end without lock and no auto restart: gates off, pending stays set.
// - Run register bits 2:0 hold run enable, direction and brake.
// - Run enable low forces all gates off, stops commutation, overrides everything.
// - Forward steps states 1 to 6 wrapping; reverse steps 6 to 1 wrapping.
// - Run and brake together turn all low gates on, all high gates off.
// - Braking does no commutation and no chopping.
// - Start of running sets pending flag and holds indicator low until locked.
// - Run low or brake holds pending flag zero and indicator high.
// - PWM low while running swaps active high gates for their low gates.
// - PWM low beyond brake time brakes like the brake bit, only when running.
// - PWM ignored during start-up and while brake bit set, except PWM brake.
// - Four-bit advance field in config 5 bits 11:8 in 1.9 degree steps.
// - Advance is applied in time, so it follows either direction unchanged.
// - High gate waits for bootstrap above turn-on limit, charging via low gate.
// - While high gate on, bootstrap below turn-off limit starts a charge cycle.
// - Bootstrap that cannot be charged raises a bootstrap fault.
// - Gates follow the phase table per state; coast all off; brake lows on.
// - First correct-polarity zero crossing per state is latched until commutation.
// - Zero crossing during start switches to closed loop and ends the sequencer.
`default_nettype none
module sensorless_bldc_run_control #(
   parameter int CW         = 24,
   parameter int HOLD_CYC   = bldc_run_pkg::HOLD_CYC,
   parameter int START_CYC  = bldc_run_pkg::START_STEP_CYC,
   parameter int END_CYC    = bldc_run_pkg::END_STEP_CYC,
   parameter int BRAKE_CYC  = bldc_run_pkg::PWM_BRAKE_CYC
) (
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   input  wire logic        i_pwm,
   input  wire logic [2:0]  i_bemf_above,
   input  wire logic [2:0]  i_boot_above_on,
   input  wire logic [2:0]  i_boot_above_off,
   output logic [2:0]       o_high_gate,
   output logic [2:0]       o_low_gate,
   output logic             o_zero_cross_speed_out,
   output logic             o_diagnostic_out_pin
);

   // Refuse settings the counters cannot hold
   if (CW < 13 || CW > 30 || HOLD_CYC >= (1 << CW) || START_CYC >= (1 << CW)
       || BRAKE_CYC >= (1 << CW) || END_CYC < 1 || END_CYC >= START_CYC || HOLD_CYC < 1)
   begin : g_bad
      $error("sensorless_bldc_run_control: counter parameters out of range");
   end

   localparam logic [CW-1:0] HOLD_N  = CW'(HOLD_CYC);
   localparam logic [CW-1:0] START_N = CW'(START_CYC);
   localparam logic [CW-1:0] END_N   = CW'(END_CYC);
   localparam logic [CW-1:0] BRAKE_N = CW'(BRAKE_CYC);
   localparam logic [CW-1:0] BLANK_N = CW'(bldc_run_pkg::BLANK_CYC);
   localparam logic [5:0]    FILT_N  = 6'(bldc_run_pkg::PWM_FILTER_CYC - 1);
   localparam logic [11:0]   BOOT_N  = 12'(bldc_run_pkg::BOOT_TIMEOUT_CYC);

   typedef struct packed {
      logic [9:0]          s1;
      logic [9:0]          s2;
      logic [9:0]          s3;
      logic [9:0]          pin;
      logic                pwm;
      logic [5:0]          filt;
      logic [CW-1:0]       lowcnt;
      logic                pwm_brk;
      logic                run;
      logic                dir;
      logic                brake_bit;
      logic                auto_restart_enable;
      logic                diagnostic_out_pin_sel;
      logic [3:0]          phase_advance_field;
      logic [3:0]          rr;
      bldc_run_pkg::mode_e mode;
      logic [2:0]          st;
      logic [CW-1:0]       tmr;
      logic [CW-1:0]       step;
      logic [CW-1:0]       since;
      logic                zc;
      logic                zero_cross_speed_out;
      logic                sensorless_pending_flag;
      logic [2:0]          chg;
      logic [2:0][11:0]    chg_cnt;
      logic [2:0]          bfault;
      logic [2:0]          gh;
      logic [2:0]          gl;
      logic                diagnostic_out_pin;
      logic                ap_wr;
      logic [7:0]          ap_addr;
      logic [31:0]         rdata;
   } state_s;

   state_s r;
   state_s n;

   // Gate masks per run state, high in 5:3, low in 2:0 (A is bit 0)
   function automatic logic [5:0] drive_mask(input logic [2:0] s);
      case (s)
         3'h1:    drive_mask = {3'b001, 3'b100};
         3'h2:    drive_mask = {3'b010, 3'b100};
         3'h3:    drive_mask = {3'b010, 3'b001};
         3'h4:    drive_mask = {3'b100, 3'b001};
         3'h5:    drive_mask = {3'b100, 3'b010};
         3'h6:    drive_mask = {3'b001, 3'b010};
         default: drive_mask = 6'h00;
      endcase
   endfunction

   // Undriven phase per run state
   function automatic logic [1:0] float_phase(input logic [2:0] s);
      case (s)
         3'h1, 3'h4: float_phase = 2'h1;
         3'h2, 3'h5: float_phase = 2'h0;
         default:    float_phase = 2'h2;
      endcase
   endfunction

   logic          take;
   logic          braking;
   logic          hit;
   logic          do_comm;
   logic          do_start;
   logic          ramp_end;
   logic [2:0]    st_next;
   logic [2:0]    hreq;
   logic [2:0]    lreq;
   logic [5:0]    mask;
   logic [1:0]    fph;
   logic [CW-1:0] dec;
   logic [CW-1:0] delay;
   logic [31:0]   rd;

   always_comb
   begin
      n        = r;
      rd       = 32'h0000_0000;
      do_comm  = 1'b0;
      do_start = 1'b0;
      ramp_end = 1'b0;
      hreq     = 3'b000;
      lreq     = 3'b000;

      // Three-stage pin synchroniser, level taken once stages 2 and 3 agree
      n.s1 = {i_boot_above_off, i_boot_above_on, i_bemf_above, i_pwm};
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < 10; i++)
      begin
         if (r.s2[i] == r.s3[i])
         begin
            n.pin[i] = r.s2[i];
         end
      end

      if (r.pin[0] != r.pwm)
      begin
         if (r.filt == FILT_N)
         begin
            n.pwm  = r.pin[0];
            n.filt = 6'h00;
         end
         else
         begin
            n.filt = r.filt + 6'h01;
         end
      end
      else
      begin
         n.filt = 6'h00;
      end

      if (r.pwm)
      begin
         n.lowcnt = '0;
      end
      else if (r.lowcnt != BRAKE_N)
      begin
         n.lowcnt = r.lowcnt + 1'b1;
      end
      n.pwm_brk = !r.pwm && (r.lowcnt == BRAKE_N);
      // brake from bit or long PWM low, only with run enable
      braking = r.run && (r.brake_bit || r.pwm_brk);

      // Bus address phase capture and read data
      take      = i_hsel && i_htrans[1] && i_hready;
      n.ap_wr   = take && i_hwrite;
      n.ap_addr = i_haddr[7:0];
      case (i_haddr[7:0])
         bldc_run_pkg::OFS_RUN:
         begin
            rd[bldc_run_pkg::RUN_ENABLE_BIT]   = r.run;
            rd[bldc_run_pkg::DIR_BIT]          = r.dir;
            rd[bldc_run_pkg::BRAKE_BIT]        = r.brake_bit;
            rd[bldc_run_pkg::AUTO_RESTART_BIT] = r.auto_restart_enable;
            rd[bldc_run_pkg::DIAGNOSTIC_OUT_PIN_SEL_BIT]     = r.diagnostic_out_pin_sel;
         end
         bldc_run_pkg::OFS_CFG5:
         begin
            rd[bldc_run_pkg::ADV_LSB +: 4] = r.phase_advance_field;
            rd[bldc_run_pkg::RR_LSB +: 4]  = r.rr;
         end
         bldc_run_pkg::OFS_DIAGNOSTIC_OUT_PIN:
         begin
            rd[bldc_run_pkg::FAULT_LSB +: 3] = r.bfault;
            rd[bldc_run_pkg::STATE_LSB +: 3] = r.st;
            rd[bldc_run_pkg::LOCKED_BIT]     = (r.mode == bldc_run_pkg::MODE_LOCKED);
            rd[bldc_run_pkg::PENDING_BIT]    = r.sensorless_pending_flag;
         end
         default: rd = 32'h0000_0000;
      endcase
      if (take && !i_hwrite)
      begin
         n.rdata = rd;
      end

      // Data phase register writes
      if (r.ap_wr)
      begin
         case (r.ap_addr)
            bldc_run_pkg::OFS_RUN:
            begin
               n.run                 = i_hwdata[bldc_run_pkg::RUN_ENABLE_BIT];
               n.dir                 = i_hwdata[bldc_run_pkg::DIR_BIT];
               n.brake_bit                 = i_hwdata[bldc_run_pkg::BRAKE_BIT];
               n.auto_restart_enable = i_hwdata[bldc_run_pkg::AUTO_RESTART_BIT];
               n.diagnostic_out_pin_sel            = i_hwdata[bldc_run_pkg::DIAGNOSTIC_OUT_PIN_SEL_BIT];
            end
            bldc_run_pkg::OFS_CFG5:
            begin
               n.phase_advance_field = i_hwdata[bldc_run_pkg::ADV_LSB +: 4];
               n.rr                  = i_hwdata[bldc_run_pkg::RR_LSB +: 4];
            end
            bldc_run_pkg::OFS_DIAGNOSTIC_OUT_PIN: n.bfault = r.bfault & ~i_hwdata[bldc_run_pkg::FAULT_LSB +: 3];
            default: n.bfault = n.bfault;
         endcase
      end

      if (!r.dir)
      begin
         st_next = (r.st == bldc_run_pkg::STATE_LAST) ? bldc_run_pkg::STATE_FIRST : r.st + 3'h1;
      end
      else
      begin
         st_next = (r.st == bldc_run_pkg::STATE_FIRST) ? bldc_run_pkg::STATE_LAST : r.st - 3'h1;
      end

      // first correct-polarity crossing after blanking, odd states rise forward
      fph = float_phase(r.st);
      hit = (r.mode == bldc_run_pkg::MODE_RAMP || r.mode == bldc_run_pkg::MODE_LOCKED)
            && !r.zc && (r.since >= BLANK_N) && (r.pin[3'(fph) + 3'h1] == (r.st[0] ^ r.dir));

      // delay from crossing to commutation, 30 deg less advance/16 of it
      // timed from measured half interval, so independent of direction
      delay = r.since - CW'((r.since >> 4) * r.phase_advance_field);
      dec   = CW'((r.step >> 5) * (r.rr + 5'h01));

      if (r.since != {CW{1'b1}})
      begin
         n.since = r.since + 1'b1;
      end

      // Start sequencer and closed-loop commutation
      case (r.mode)
         bldc_run_pkg::MODE_IDLE:
         begin
            if (r.run && !braking)
            begin
               do_start = 1'b1;
            end
         end
         bldc_run_pkg::MODE_HOLD:
         begin
            if (r.tmr == '0)
            begin
               n.mode  = bldc_run_pkg::MODE_RAMP;
               n.tmr   = r.step;
               do_comm = 1'b1;
            end
            else
            begin
               n.tmr = r.tmr - 1'b1;
            end
         end
         bldc_run_pkg::MODE_RAMP:
         begin
            if (hit)
            begin
               n.mode                    = bldc_run_pkg::MODE_LOCKED;
               n.zc                      = 1'b1;
               n.zero_cross_speed_out                   = 1'b1;
               n.tmr                     = delay;
               n.sensorless_pending_flag = 1'b0;
            end
            else if (r.tmr == '0)
            begin
               if (r.step <= END_N)
               begin
                  ramp_end = 1'b1;
               end
               else
               begin
                  do_comm = 1'b1;
                  n.step  = (r.step - dec > END_N) ? r.step - dec : END_N;
                  n.tmr   = (r.step - dec > END_N) ? r.step - dec : END_N;
               end
            end
            else
            begin
               n.tmr = r.tmr - 1'b1;
            end
         end
         bldc_run_pkg::MODE_LOCKED:
         begin
            if (hit)
            begin
               n.zc    = 1'b1;
               n.zero_cross_speed_out = 1'b1;
               n.tmr   = delay;
            end
            else if (r.zc && r.tmr == '0)
            begin
               do_comm = 1'b1;
            end
            else if (r.zc)
            begin
               n.tmr = r.tmr - 1'b1;
            end
            else if (r.since >= START_N)
            begin
               ramp_end = 1'b1;
            end
         end
         bldc_run_pkg::MODE_STALL:
         begin
            n.sensorless_pending_flag = 1'b1;
         end
         default: n.mode = bldc_run_pkg::MODE_IDLE;
      endcase

      // retry on failed start when auto restart set
      if (ramp_end && r.auto_restart_enable)
      begin
         do_start = 1'b1;
      end
      else if (ramp_end)
      begin
         n.mode  = bldc_run_pkg::MODE_STALL;
         n.zero_cross_speed_out = 1'b0;
      end

      // commutation drops speed output and clears crossing latch
      if (do_comm)
      begin
         n.st    = st_next;
         n.since = '0;
         n.zc    = 1'b0;
         n.zero_cross_speed_out = 1'b0;
      end

      // start sets pending, forces known position
      if (do_start)
      begin
         n.mode                    = bldc_run_pkg::MODE_HOLD;
         n.st                      = bldc_run_pkg::STATE_FIRST;
         n.tmr                     = HOLD_N;
         n.step                    = START_N;
         n.since                   = '0;
         n.zc                      = 1'b0;
         n.zero_cross_speed_out                   = 1'b0;
         n.sensorless_pending_flag = 1'b1;
      end

      // run low coasts; brake halts sequencer; pending cleared
      if (!r.run || braking)
      begin
         n.mode                    = bldc_run_pkg::MODE_IDLE;
         n.zero_cross_speed_out                   = 1'b0;
         n.zc                      = 1'b0;
         n.sensorless_pending_flag = 1'b0;
      end

      // phase table drive in start and run modes
      mask = drive_mask(r.st);
      if (braking)
      begin
         lreq = 3'b111;
      end
      else if (r.run && (r.mode == bldc_run_pkg::MODE_HOLD || r.mode == bldc_run_pkg::MODE_RAMP
               || r.mode == bldc_run_pkg::MODE_LOCKED))
      begin
         hreq = mask[5:3];
         lreq = mask[2:0];
         // chop high side when PWM low; only once locked
         if (r.mode == bldc_run_pkg::MODE_LOCKED && !r.pwm)
         begin
            lreq = mask[2:0] | mask[5:3];
            hreq = 3'b000;
         end
      end

      // Bootstrap charge management per phase
      for (int i = 0; i < 3; i++)
      begin
         if (!hreq[i])
         begin
            n.chg[i]     = 1'b0;
            n.chg_cnt[i] = 12'h000;
         end
         else if (r.chg[i])
         begin
            if (r.pin[4 + i])
            begin
               n.chg[i] = 1'b0;
            end
            else if (r.chg_cnt[i] == BOOT_N)
            begin
               // timeout marks fault, set wins over clear
               n.bfault[i] = 1'b1;
            end
            else
            begin
               n.chg_cnt[i] = r.chg_cnt[i] + 12'h001;
            end
         end
         // check turn-on limit before enabling high gate
         else if (!r.gh[i] && !r.pin[4 + i])
         begin
            n.chg[i]     = 1'b1;
            n.chg_cnt[i] = 12'h000;
         end
         else if (r.gh[i] && !r.pin[7 + i])
         begin
            n.chg[i]     = 1'b1;
            n.chg_cnt[i] = 12'h000;
         end
         n.gh[i] = hreq[i] && !n.chg[i];
         n.gl[i] = lreq[i] || (hreq[i] && n.chg[i]);
      end

      // select set: indicator high when sensorless or inactive; select clear: fault-free level
      n.diagnostic_out_pin = r.diagnostic_out_pin_sel ? !n.sensorless_pending_flag : !(|n.bfault);
   end

   // State register
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         r                     <= '0;
         r.pwm                 <= 1'b1;
         r.st                  <= bldc_run_pkg::STATE_FIRST;
         r.rr                  <= bldc_run_pkg::RR_RST;
         r.phase_advance_field <= bldc_run_pkg::ADV_RST;
         r.mode                <= bldc_run_pkg::MODE_IDLE;
         r.diagnostic_out_pin                <= 1'b1;
      end
      else
      begin
         r <= n;
      end
   end

   // Outputs
   assign o_hreadyout            = 1'b1;
   assign o_hresp                = 1'b0;
   assign o_hrdata               = r.rdata;
   assign o_high_gate            = r.gh;
   assign o_low_gate             = r.gl;
   assign o_zero_cross_speed_out = r.zero_cross_speed_out;
   assign o_diagnostic_out_pin   = r.diagnostic_out_pin;

endmodule
`default_nettype wire

// ---- verification/bldc_run_checker.sv ----
// Port checker for the run control block
`default_nettype none
module bldc_run_checker (
   input wire logic        i_mclk,
   input wire logic        i_rst_n,
   input wire logic        i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0]  i_htrans,
   input wire logic        i_hwrite,
   input wire logic        i_hready,
   input wire logic [31:0] i_hwdata,
   input wire logic [31:0] o_hrdata,
   input wire logic [2:0]  i_boot_above_on,
   input wire logic [2:0]  i_boot_above_off,
   input wire logic [2:0]  o_high_gate,
   input wire logic [2:0]  o_low_gate,
   input wire logic        o_zero_cross_speed_out,
   input wire logic        o_diagnostic_out_pin
);
   logic       wr;
   logic       rd;
   logic [4:0] sh;
   wire        take = i_hsel && i_htrans[1] && i_hready && i_haddr[7:0] == 8'h00;
   wire        run  = sh[0];
   wire        brake_bit  = sh[2];
   wire        sel  = sh[4];
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Shadow of the run register from bus traffic
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr <= 1'b0;
         rd <= 1'b0;
         sh <= 5'h00;
      end
      else
      begin
         wr <= take && i_hwrite;
         rd <= take && !i_hwrite;
         if (wr)
            sh <= i_hwdata[4:0];
      end
   end
   // Settled control states
   sequence s_stopped;
      !run [*3];
   endsequence
   sequence s_braking;
      (run && brake_bit) [*3];
   endsequence
   a_run_readback: assert property (rd |-> o_hrdata[4:0] == sh)
      else $error("run register reads back wrong");
   a_coast_stop: assert property (s_stopped |-> (o_high_gate | o_low_gate) == 3'h0)
      else $error("gates on while stopped");
   a_brake_lows: assert property (s_braking |-> {o_high_gate, o_low_gate} == 6'h07)
      else $error("brake pattern wrong");
   a_diagnostic_out_pin_idle: assert property ((sel && (!run || brake_bit)) [*3] |-> o_diagnostic_out_pin)
      else $error("indicator low while inactive");
   a_diagnostic_out_pin_start: assert property ($rose(run) && !brake_bit && sel |-> ##[1:3] !o_diagnostic_out_pin)
      else $error("indicator not low at start");
   a_zero_cross_speed_out_lock: assert property ($rose(o_zero_cross_speed_out) && sel && run && !brake_bit
      |-> ##[0:4] o_diagnostic_out_pin)
      else $error("crossing without sensorless indication");
   a_gate_excl: assert property ((o_high_gate & o_low_gate) == 3'h0)
      else $error("high and low gate on together");
   a_boot_hold: assert property (((i_boot_above_on | i_boot_above_off) == 3'h0) [*8]
      |-> o_high_gate == 3'h0)
      else $error("high gate on with empty bootstrap");
endmodule
bind sensorless_bldc_run_control bldc_run_checker i_chk (.*);
`default_nettype wire

// ---- verification/bldc_bridge_model.sv ----
// Behavioural bridge, rotor comparator and bootstrap supplies
`default_nettype none
module bldc_bridge_model (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic [2:0] i_high,
   input  wire logic [2:0] i_low,
   input  wire logic       i_spin,
   input  wire logic       i_dir,
   input  wire logic       i_dead,
   output logic      [2:0] o_bemf,
   output logic      [2:0] o_boot
);
   logic [8:0] cnt;
   logic [2:0] chg;
   wire        odd = (i_low == {i_high[0], i_high[2:1]});
   // Capacitor charges through its low switch
   always_ff @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt <= 9'h000;
         chg <= 3'h0;
      end
      else
      begin
         cnt <= cnt + 9'h001;
         chg <= i_dead ? 3'h0 : chg | i_low;
      end
   end
   // A standing rotor never shows a matching crossing
   assign o_bemf = i_spin ? {3{cnt[8]}} : {3{~(odd ^ i_dir)}};
   assign o_boot = chg;
endmodule
`default_nettype wire

// ---- verification/sensorless_bldc_run_control_tb.sv ----
// Self-checking bench for the run control block
`default_nettype none
module sensorless_bldc_run_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_mclk;
   logic        i_rst_n;
   logic        i_hsel;
   logic [31:0] i_haddr;
   logic [1:0]  i_htrans;
   logic        i_hwrite;
   logic [31:0] i_hwdata;
   logic        i_pwm;
   logic        o_hreadyout;
   logic        o_hresp;
   logic [31:0] o_hrdata;
   logic [2:0]  o_high_gate;
   logic [2:0]  o_low_gate;
   logic        o_zero_cross_speed_out;
   logic        o_diagnostic_out_pin;
   logic [2:0]  bemf;
   logic [2:0]  boot;
   logic        spin;
   logic        dir;
   logic        dead;
   logic [31:0] q;
   int unsigned n;
   int          failures;
   int          comparisons;
   sensorless_bldc_run_control #(.HOLD_CYC(200), .START_CYC(3000), .END_CYC(1500),
      .BRAKE_CYC(300)) i_dut (.*, .i_hsize(3'h2), .i_hready(o_hreadyout),
      .i_bemf_above(bemf), .i_boot_above_on(boot), .i_boot_above_off(boot));
   bldc_bridge_model i_bridge (.i_mclk, .i_rst_n, .i_high(o_high_gate), .i_low(o_low_gate),
      .i_spin(spin), .i_dir(dir), .i_dead(dead), .o_bemf(bemf), .o_boot(boot));
   // Clock
   initial
   begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end
   // Commutation state shown by the gates, 0 if none
   function automatic int st(input logic [5:0] g);
      case (g)
         6'h0c: st = 1;
         6'h14: st = 2;
         6'h11: st = 3;
         6'h21: st = 4;
         6'h22: st = 5;
         6'h0a: st = 6;
         default: st = 0;
      endcase
   endfunction
   function automatic int nxt(input int s, input logic d);
      nxt = d ? (s == 1 ? 6 : s - 1) : s % 6 + 1;
   endfunction
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // One single transfer, entered just after an edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      i_hsel <= 1'b1;
      i_htrans <= 2'h2;
      i_hwrite <= w;
      i_haddr <= {24'h000000, a};
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
      q = o_hrdata;
      check(o_hresp, 1'b0);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      check(q & m, e);
   endtask
   // Follow the gates and count zero_cross_speed_out rises
   task automatic rotate(input logic d);
      int p;
      int s;
      int r;
      logic t;
      p = 0;
      r = 0;
      t = 1'b0;
      repeat (15000)
      begin
         @(negedge i_mclk);
         s = st({o_high_gate, o_low_gate});
         if (s != 0 && p != 0 && s != p)
            check(s, nxt(p, d));
         if (s != 0)
            p = s;
         r += int'(o_zero_cross_speed_out && !t);
         t = o_zero_cross_speed_out;
      end
      check(r > 2, 1'b1);
      check(o_diagnostic_out_pin, 1'b1);
      @(posedge i_mclk);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #400000;
      failures++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      i_rst_n = 1'b0;
      i_hsel = 1'b0;
      i_haddr = 32'h0;
      i_htrans = 2'h0;
      i_hwrite = 1'b0;
      i_hwdata = 32'h0;
      i_pwm = 1'b1;
      spin = 1'b0;
      dir = 1'b0;
      dead = 1'b0;
      failures = 0;
      comparisons = 0;
      void'($urandom(94));
      repeat (12) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      rdc(8'h00, 32'hffffffff, 32'h0);
      rdc(8'h04, 32'hffffffff, 32'h4);
      rdc(8'h08, 32'hffffffff, 32'(bldc_run_pkg::STATE_FIRST) << bldc_run_pkg::STATE_LSB);
      bus(1'b1, 8'h0c, 32'hffffffff);
      rdc(8'h0c, 32'hffffffff, 32'h0);
      repeat (4)
      begin
         n = $urandom & 32'h0f0f;
         bus(1'b1, 8'h04, n);
         rdc(8'h04, 32'hffffffff, n);
      end
      // No back-EMF: stop without retry, then retry
      bus(1'b1, 8'h04, 32'h0304);
      bus(1'b1, 8'h00, 32'h11);
      repeat (16000) @(posedge i_mclk);
      check({o_high_gate, o_low_gate}, 6'h00);
      rdc(8'h08, 32'h200, 32'h200);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h00, 32'h19);
      n = 0;
      repeat (12000) @(posedge i_mclk);
      repeat (4000)
      begin
         @(posedge i_mclk);
         n += int'({o_high_gate, o_low_gate} != 6'h00);
      end
      check(n == 4000, 1'b1);
      rdc(8'h08, 32'h200, 32'h200);
      // Turning rotor locks forward
      bus(1'b1, 8'h00, 32'h0);
      spin <= 1'b1;
      bus(1'b1, 8'h00, 32'h11);
      rotate(1'b0);
      rdc(8'h08, 32'h300, 32'h100);
      // Short PWM low chops, long PWM low brakes
      i_pwm <= 1'b0;
      repeat (50 + $urandom % 40) @(posedge i_mclk);
      check(o_high_gate, 3'h0);
      check($countones(o_low_gate), 2);
      repeat (400) @(posedge i_mclk);
      check({o_high_gate, o_low_gate}, 6'h07);
      i_pwm <= 1'b1;
      // Let the filtered PWM and its brake clear before restarting
      repeat (60) @(posedge i_mclk);
      // Reverse rotation
      bus(1'b1, 8'h00, 32'h0);
      dir <= 1'b1;
      bus(1'b1, 8'h00, 32'h13);
      rotate(1'b1);
      // Brake bit, then a bootstrap that never charges
      bus(1'b1, 8'h00, 32'h15);
      repeat (10) @(posedge i_mclk);
      check({o_high_gate, o_low_gate, o_diagnostic_out_pin}, 7'h0f);
      bus(1'b1, 8'h00, 32'h0);
      dead <= 1'b1;
      bus(1'b1, 8'h00, 32'h11);
      repeat (3000) @(posedge i_mclk);
      bus(1'b0, 8'h08, 32'h0);
      check(q[2:0] != 3'h0, 1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
